// ==== rtl/pfmc_pkg.sv ====
// Shared constants for the pixel format and memory continue command logic.
// Assumes an 8-bit host bus with command codes in the low byte.
package pfmc_pkg;
  // Command codes
  localparam logic [7:0] PFMC_CMD_SW_RESET       = 8'h01;
  localparam logic [7:0] PFMC_CMD_MEM_WRITE      = 8'h2C;
  localparam logic [7:0] PFMC_CMD_MEM_READ       = 8'h2E;
  localparam logic [7:0] PFMC_CMD_PIXEL_FORMAT   = 8'h3A;
  localparam logic [7:0] PFMC_CMD_WRITE_CONTINUE = 8'h3C;
  localparam logic [7:0] PFMC_CMD_READ_CONTINUE  = 8'h3E;
  // Interface pixel format field
  localparam int         PFMC_FMT_LSB   = 0;
  localparam logic [1:0] PFMC_FMT_16BPP = 2'h1;
  localparam logic [1:0] PFMC_FMT_18BPP = 2'h2;
  localparam logic [1:0] PFMC_FMT_24BPP = 2'h3;
  localparam logic [1:0] PFMC_FMT_RESET = PFMC_FMT_24BPP;
  // Bytes per pixel on the 8-bit bus, and bytes returned per read pixel
  localparam logic [1:0] PFMC_BYTES_16  = 2'h2;
  localparam logic [1:0] PFMC_BYTES_3   = 2'h3;
  // Frame memory word: 6 bits per colour
  localparam int         PFMC_CH_W      = 6;
  localparam int         PFMC_PIX_W     = 3 * PFMC_CH_W;
  // Command decoder states
  typedef enum logic [2:0] {
    PFMC_IDLE,
    PFMC_FORMAT_PARAM,
    PFMC_WRITING,
    PFMC_READING
  } pfmc_state_e;
endpackage : pfmc_pkg

// ==== rtl/pfmc_frame_mem.sv ====
// Frame memory: one write port, one read port with registered read data.
// Assumes a single clock; contents are never reset.
`timescale 1ns/1ps
module pfmc_frame_mem #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 18
) (
  // Clock
  input  wire logic              clk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data_q
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // No reset on the array: contents survive every reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule : pfmc_frame_mem

// ==== rtl/pfmc_host_cmd.sv ====
// Host command interpreter: pixel format, memory write/read and their continues.
// Assumes host pins are synchronous to clk and strobes stay low at least one clock.
`timescale 1ns/1ps
module pfmc_host_cmd
  import pfmc_pkg::*;
#(
  parameter int COL_W  = 8,
  parameter int PAGE_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Host bus
  input  wire logic              cmd_param_select,
  input  wire logic              write_strobe_n,
  input  wire logic              read_strobe_n,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe_n,
  // Window and scan order from the address setup logic
  input  wire logic [COL_W-1:0]  first_column,
  input  wire logic [COL_W-1:0]  last_column,
  input  wire logic [PAGE_W-1:0] first_page,
  input  wire logic [PAGE_W-1:0] last_page,
  input  wire logic              row_column_exchange,
  // Status
  output logic [1:0]             interface_pixel_format_field,
  output logic                   transfer_active
);
  import pfmc_pkg::*;

  pfmc_state_e       state_q, state_d;
  logic [1:0]        fmt_q;
  logic [COL_W-1:0]  col_q;
  logic [PAGE_W-1:0] page_q;
  logic              done_q;
  logic [1:0]        byte_cnt_q;
  logic [7:0]        b0_q, b1_q;
  logic              wr_prev_q, rd_prev_q;
  logic [7:0]        data_out_q;
  logic              oe_n_q;
  logic              act_q;
  logic [PFMC_PIX_W-1:0] rd_pix;

  // Host strobe edges
  wire wr_rise   = write_strobe_n & ~wr_prev_q;
  wire rd_rise   = read_strobe_n & ~rd_prev_q;
  wire cmd_wr    = wr_rise & ~cmd_param_select;
  wire param_wr  = wr_rise & cmd_param_select;

  // Format decode; the reserved code falls back to 24bpp packing
  wire       is16      = (fmt_q == PFMC_FMT_16BPP);
  wire       is18      = (fmt_q == PFMC_FMT_18BPP);
  wire [1:0] wr_bytes  = is16 ? PFMC_BYTES_16 : PFMC_BYTES_3;
  wire       last_byte = (byte_cnt_q == wr_bytes - 2'h1);

  // Colour lookup: expand or trim each channel to 6 bits
  wire [5:0] lut_r = is16 ? {b0_q[7:3], b0_q[7]} : b0_q[7:2];
  // 16bpp green straddles both bytes; its low half is on the bus now
  wire [5:0] lut_g = is16 ? {b0_q[2:0], data_in[7:5]} : b1_q[7:2];
  wire [5:0] lut_b = is16 ? {data_in[4:0], data_in[4]} : data_in[7:2];
  wire [PFMC_PIX_W-1:0] wr_pix = {lut_r, lut_g, lut_b};
  wire unused_is18 = is18;

  // Address generator: next position in the window
  wire col_end  = (col_q == last_column);
  wire page_end = (page_q == last_page);
  wire win_end  = col_end & page_end;
  logic [COL_W-1:0]  col_nx;
  logic [PAGE_W-1:0] page_nx;
  always_comb begin
    col_nx  = col_q;
    page_nx = page_q;
    if (!row_column_exchange) begin
      if (!col_end) begin
        col_nx = col_q + COL_W'(1);
      end else begin
        col_nx  = first_column;
        page_nx = page_end ? first_page : page_q + PAGE_W'(1);
      end
    end else begin
      if (!page_end) begin
        page_nx = page_q + PAGE_W'(1);
      end else begin
        page_nx = first_page;
        col_nx  = col_end ? first_column : col_q + COL_W'(1);
      end
    end
  end

  // Memory accesses
  wire pix_write = (state_q == PFMC_WRITING) & param_wr & last_byte & ~done_q;
  wire pix_read  = (state_q == PFMC_READING) & rd_rise & cmd_param_select
                   & (byte_cnt_q == PFMC_BYTES_3) & ~done_q;
  wire step      = pix_write | pix_read;
  wire start_win = cmd_wr & ((data_in == PFMC_CMD_MEM_WRITE) | (data_in == PFMC_CMD_MEM_READ));

  pfmc_frame_mem #(
    .ADDR_W (COL_W + PAGE_W),
    .DATA_W (PFMC_PIX_W)
  ) u_mem (
    .clk       (clk),
    .wr_en     (pix_write),
    .wr_addr   ({page_q, col_q}),
    .wr_data   (wr_pix),
    .rd_addr   ({page_q, col_q}),
    .rd_data_q (rd_pix)
  );

  // Command decode; any state accepts a command
  always_comb begin
    state_d = state_q;
    if (cmd_wr) begin
      case (data_in)
        PFMC_CMD_PIXEL_FORMAT:   state_d = PFMC_FORMAT_PARAM;
        PFMC_CMD_MEM_WRITE,
        PFMC_CMD_WRITE_CONTINUE: state_d = PFMC_WRITING;
        PFMC_CMD_MEM_READ,
        PFMC_CMD_READ_CONTINUE:  state_d = PFMC_READING;
        default:                 state_d = PFMC_IDLE;
      endcase
    end else if (state_q == PFMC_FORMAT_PARAM && param_wr) begin
      state_d = PFMC_IDLE;
    end
  end

  // Read byte select: index 0 is the dummy, then R, G, B
  logic [7:0] rd_byte;
  always_comb begin
    case (byte_cnt_q)
      2'h1:    rd_byte = {rd_pix[17:12], 2'h0};
      2'h2:    rd_byte = {rd_pix[11:6], 2'h0};
      2'h3:    rd_byte = {rd_pix[5:0], 2'h0};
      default: rd_byte = 8'h00;
    endcase
  end

  // State, strobe history and format register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= PFMC_IDLE;
      act_q     <= 1'b0;
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
      fmt_q     <= PFMC_FMT_RESET;
    end else begin
      state_q   <= state_d;
      // Registered copy so the status pin comes from a flop
      act_q     <= (state_d == PFMC_WRITING) | (state_d == PFMC_READING);
      wr_prev_q <= write_strobe_n;
      rd_prev_q <= read_strobe_n;
      // Software reset command does not touch the format
      if (state_q == PFMC_FORMAT_PARAM && param_wr) begin
        fmt_q <= data_in[PFMC_FMT_LSB +: 2];
      end
    end
  end

  // Counters and byte assembly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      col_q      <= '0;
      page_q     <= '0;
      done_q     <= 1'b0;
      byte_cnt_q <= 2'h0;
      b0_q       <= 8'h00;
      b1_q       <= 8'h00;
    end else begin
      if (start_win) begin
        col_q  <= first_column;
        page_q <= first_page;
      end else if (step) begin
        col_q  <= col_nx;
        page_q <= page_nx;
      end
      // Capacity reached: stop until the next transfer command
      if (cmd_wr) begin
        done_q <= 1'b0;
      end else if (step && win_end) begin
        done_q <= 1'b1;
      end
      if (cmd_wr) begin
        byte_cnt_q <= 2'h0;
      end else if (state_q == PFMC_WRITING && param_wr) begin
        byte_cnt_q <= last_byte ? 2'h0 : byte_cnt_q + 2'h1;
        if (byte_cnt_q == 2'h0) b0_q <= data_in;
        if (byte_cnt_q == 2'h1) b1_q <= data_in;
      end else if (state_q == PFMC_READING && rd_rise && cmd_param_select) begin
        byte_cnt_q <= (byte_cnt_q == PFMC_BYTES_3) ? 2'h1 : byte_cnt_q + 2'h1;
      end
    end
  end

  // Read data pins: driven, one clock late, only while a read strobe is low with select high in a read transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out_q <= 8'h00;
      oe_n_q     <= 1'b1;
    end else begin
      data_out_q <= rd_byte;
      oe_n_q     <= ~((state_q == PFMC_READING) & ~read_strobe_n & cmd_param_select);
    end
  end

  assign data_out                     = data_out_q;
  assign data_oe_n                    = oe_n_q;
  assign interface_pixel_format_field = fmt_q;
  assign transfer_active              = act_q;
endmodule : pfmc_host_cmd

// ==== tb/pfmc_host_model.sv ====
// Host model: 8-bit command and parameter bus master.
// Assumes tasks are entered at a falling clock edge.
`timescale 1ns/1ps
module pfmc_host_model (
  // Clock
  input  wire logic       clk,
  // Host bus
  output logic            cmd_param_select,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out
);
  // Idle bus, strobes high
  initial begin
    cmd_param_select = 1'b0;
    write_strobe_n   = 1'b1;
    read_strobe_n    = 1'b1;
    data_in          = 8'h00;
  end
  // Byte held one clk low, then rises
  task automatic wr(input logic s, input logic [7:0] v);
    cmd_param_select = s;
    data_in          = v;
    write_strobe_n   = 1'b0;
    @(negedge clk);
    write_strobe_n = 1'b1;
    @(negedge clk);
  endtask : wr
  // Read low three clk so data settles; data_in flips as the strobe falls
  task automatic rd(output logic [7:0] v);
    cmd_param_select = 1'b1;
    read_strobe_n    = 1'b0;
    data_in          = ~data_in;
    repeat (3) @(negedge clk);
    v             = data_out;
    read_strobe_n = 1'b1;
    @(negedge clk);
  endtask : rd
endmodule : pfmc_host_model

// ==== tb/pfmc_host_cmd_chk.sv ====
// Checker on the host command interpreter ports.
// Assumes one clock and the async active-high reset.
`timescale 1ns/1ps
module pfmc_host_cmd_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Host bus
  input wire logic       cmd_param_select,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  // Status
  input wire logic [1:0] interface_pixel_format_field,
  input wire logic       transfer_active
);
  logic ws_q;
  // Taken command or parameter byte
  wire take = write_strobe_n && !ws_q && !cmd_param_select;
  wire prm  = write_strobe_n && !ws_q && cmd_param_select;
  // Strobe history, high after reset as in the device
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ws_q <= 1'b1;
    end else begin
      ws_q <= write_strobe_n;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence fmt_s;
    take && data_in == 8'h3A ##2 prm;
  endsequence
  sequence rdc_s;
    take && data_in == 8'h3E ##1 $fell(read_strobe_n) && cmd_param_select;
  endsequence
  fmt_hw_a: assert property ($fell(rst) |-> interface_pixel_format_field == 2'h3)
    else $error("format not 24bpp after reset");
  fmt_set_a: assert property (fmt_s |=> interface_pixel_format_field == $past(data_in[1:0]))
    else $error("format field not taken");
  sw_keep_a: assert property (take && data_in == 8'h01 |=> $stable(interface_pixel_format_field))
    else $error("software reset changed format");
  xfer_start_a: assert property (take && data_in inside {8'h2C, 8'h3C, 8'h3E} |=> transfer_active)
    else $error("transfer not started");
  xfer_stop_a: assert property (take && !(data_in inside {8'h2C, 8'h2E, 8'h3C, 8'h3E}) |=> !transfer_active)
    else $error("transfer not ended");
  oe_idle_a: assert property (!transfer_active && !$past(transfer_active) |-> data_oe_n)
    else $error("bus driven outside read");
  dummy_read_a: assert property (rdc_s |-> ##2 data_out == 8'h00)
    else $error("first read byte not dummy");
  read_18_a: assert property (!data_oe_n |-> data_out[1:0] == 2'h0)
    else $error("read byte not 6-bit channel");
endmodule : pfmc_host_cmd_chk
bind pfmc_host_cmd pfmc_host_cmd_chk i_chk (
  .clk(clk), .rst(rst), .cmd_param_select(cmd_param_select), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .interface_pixel_format_field(interface_pixel_format_field), .transfer_active(transfer_active)
);

// ==== tb/pixel_format_memory_continue_bench.sv ====
// Bench for the host command interpreter on a 2x2 window.
// Assumes the host model drives the bus from falling edges.
`timescale 1ns/1ps
module pixel_format_memory_continue_bench;
  import pfmc_pkg::*;
  logic       clk, rst, sel, wsn, rsn, oe_n, act, mv;
  logic [7:0] din, dout;
  logic [1:0] fmt;
  // Window edges, driven rather than tied
  logic [3:0] fc, lc, fp, lp;
  int         mismatches, total_checks;
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  pfmc_host_cmd #(.COL_W(4), .PAGE_W(4)) i_pfmc_host_cmd (
    .clk(clk), .rst(rst), .cmd_param_select(sel), .write_strobe_n(wsn), .read_strobe_n(rsn),
    .data_in(din), .data_out(dout), .data_oe_n(oe_n), .first_column(fc), .last_column(lc),
    .first_page(fp), .last_page(lp), .row_column_exchange(mv),
    .interface_pixel_format_field(fmt), .transfer_active(act));
  pfmc_host_model i_pfmc_host_model (.clk(clk), .cmd_param_select(sel), .write_strobe_n(wsn),
    .read_strobe_n(rsn), .data_in(din), .data_out(dout));
  // Pixel byte; low bits set so their loss shows
  function automatic logic [7:0] pix(input int k, input int j);
    return 8'(k * 48 + j * 16 + 3);
  endfunction : pix
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic w(input logic s, input logic [7:0] v);
    i_pfmc_host_model.wr(s, v);
  endtask : w
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic t_format;
    chk("format", {6'h0, fmt}, 8'h03);
    for (int f = 2; f < 5; f++) begin
      w(1'b0, 8'h3A);
      w(1'b1, 8'((f % 3) + 1));
      @(negedge clk);
      chk("format", {6'h0, fmt}, 8'((f % 3) + 1));
    end
    w(1'b0, 8'h01);
    @(negedge clk);
    chk("format", {6'h0, fmt}, 8'h02);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("format", {6'h0, fmt}, 8'h03);
    w(1'b0, 8'h3A);
    w(1'b1, 8'h02);
    $display("format test done");
  endtask : t_format
  // Five pixels into four places, read back page first
  task automatic t_pixels;
    logic [7:0] r;
    mv = 1'b0;
    w(1'b0, 8'h2C);
    for (int k = 0; k < 5; k++) begin
      if (k == 2) w(1'b0, 8'h3C);
      for (int j = 0; j < 3; j++) w(1'b1, pix(k, j));
    end
    mv = 1'b1;
    for (int n = 0; n < 4; n++) begin
      if (n % 2 == 0) begin
        w(1'b0, n == 0 ? 8'h2E : 8'h3E);
        i_pfmc_host_model.rd(r);
        chk("dummy", r, 8'h00);
      end
      for (int j = 0; j < 3; j++) begin
        i_pfmc_host_model.rd(r);
        chk("pixel", r, pix((n % 2) * 2 + n / 2, j) & 8'hFC);
      end
    end
    $display("pixel test done");
  endtask : t_pixels
  // 16bpp pixel written, kept over a reset, read back as 18-bit
  task automatic t_pack16;
    logic [7:0] r;
    w(1'b0, 8'h3A);
    w(1'b1, 8'h01);
    w(1'b0, 8'h2C);
    chk("active", {7'h0, act}, 8'h01);
    w(1'b1, 8'hB3);
    w(1'b1, 8'h8D);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    w(1'b0, 8'h2E);
    i_pfmc_host_model.rd(r);
    chk("dummy", r, 8'h00);
    i_pfmc_host_model.rd(r);
    chk("red", r, 8'hB4);
    i_pfmc_host_model.rd(r);
    chk("green", r, 8'h70);
    i_pfmc_host_model.rd(r);
    chk("blue", r, 8'h68);
    chk("oe", {7'h0, oe_n}, 8'h01);
    w(1'b0, 8'h01);
    chk("active", {7'h0, act}, 8'h00);
    $display("pack16 test done");
  endtask : t_pack16
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    rst          = 1'b1;
    mv           = 1'b0;
    fc           = 4'h1;
    lc           = 4'h2;
    fp           = 4'h1;
    lp           = 4'h2;
    mismatches   = 0;
    total_checks = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_format();
    t_pixels();
    t_pack16();
    wrap_up();
  end
endmodule : pixel_format_memory_continue_bench
